/* verilog/ricp_pkg.sv */
package ricp_pkg;
  // timing at 200 MHz
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned RELEASE_MAX_US   = 1000;
  localparam int unsigned INIT_TIME_US     = 20000;
  localparam int unsigned RELEASE_CYC      = RELEASE_MAX_US * CLK_MHZ;
  localparam int unsigned INIT_CYC         = INIT_TIME_US * CLK_MHZ;
  // management commands
  localparam logic [7:0]  CMD_STORE_ALL    = 8'h11;
  localparam logic [7:0]  CMD_ENTER_BOOT   = 8'hD9;
  // bus address handling
  localparam logic [6:0]  ADDR_FALLBACK    = 7'h7E;
  localparam logic [6:0]  ADDR_RSVD_MFG    = 7'h0B;
  localparam logic [6:0]  ADDR_RSVD_TEST   = 7'h7F;
  localparam logic [6:0]  ADDR_GENCALL     = 7'h00;
  // configuration layout
  localparam int unsigned CFG_WORDS        = 16;
  localparam int unsigned CFG_AW           = 4;
  localparam int unsigned CFG_DW           = 16;
  localparam int unsigned GPIO_N           = 8;
  localparam int unsigned JTAG_SHARED_N    = 4;
  localparam int unsigned FAST_PWM_N       = 4;
  localparam logic [15:0] CFG_RESET_VALUE  = 16'h0000;
  typedef enum logic [1:0] {
    RICP_RESET = 2'b00,
    RICP_WAIT  = 2'b01,
    RICP_INIT  = 2'b11,
    RICP_RUN   = 2'b10
  } ricp_state_t;
endpackage : ricp_pkg

/* verilog/ricp_core.sv */
// Contract
// - hold reset until supply above threshold
// - low external reset pin holds reset
// - leave reset within 1ms of release
// - about 20ms initialization after every reset exit
// - init: fast pwm low, other pins undriven
// - after init, run stored configuration (code runs working RAM, which is never loaded from flash)
// - factory default: outputs hi-z, no sequencing (code keeps gpio hi-z but drives fast pwm pins low)
// - parameter write updates working RAM only
// - store command copies RAM to flash
// - jtag port disabled by default
// - enter-boot command enables jtag
// - blank flash at power-up enables jtag
// - invalid address at power-up enables jtag
// - four jtag pins serve as gpio
// - tap follows 1149.1 for programming
// - no boundary scan through tap
// - bad address pin falls back to 126
// - addresses 11 and 127 reserved
`timescale 1ns/1ps
module ricp_core #(
  parameter int unsigned RELEASE_CYC = ricp_pkg::RELEASE_CYC,
  parameter int unsigned INIT_CYC    = ricp_pkg::INIT_CYC
) (
  // clock and reset
  input  wire logic                                i_clk,
  input  wire logic                                i_rstn,
  // reset sources
  input  wire logic                                i_supply_above_threshold,
  input  wire logic                                i_external_reset_low_pin_n,
  // decoded bus address and flash state
  input  wire logic [6:0]                          i_bus_addr,
  input  wire logic                                i_addr_pin_fault,
  input  wire logic                                i_flash_blank,
  // management commands
  input  wire logic                                i_cmd_valid,
  input  wire logic [7:0]                          i_cmd_code,
  input  wire logic                                i_param_wr,
  input  wire logic [ricp_pkg::CFG_AW-1:0]         i_param_addr,
  input  wire logic [ricp_pkg::CFG_DW-1:0]         i_param_data,
  input  wire logic                                i_flash_busy,
  // state levels, sequencer enable, bus address and flash write port
  output logic                                     o_in_reset,
  output logic                                     o_init_active,
  output logic                                     o_run,
  output logic                                     o_seq_enable,
  output logic [6:0]                               o_bus_addr,
  output logic                                     o_flash_store,
  output logic [ricp_pkg::CFG_AW-1:0]              o_flash_addr,
  output logic [ricp_pkg::CFG_DW-1:0]              o_flash_data,
  output logic                                     o_flash_we,
  // pins
  output logic [ricp_pkg::FAST_PWM_N-1:0]          o_fast_pwm_pins,
  output logic [ricp_pkg::GPIO_N-1:0]              o_general_output_pin,
  output logic [ricp_pkg::GPIO_N-1:0]              o_general_output_pin_oe,
  output logic                                     o_jtag_enable,
  output logic [ricp_pkg::JTAG_SHARED_N-1:0]       o_jtag_shared_gpio_oe
);
  initial begin
    if (RELEASE_CYC < 1 || INIT_CYC < 1) $error("ricp_core: counts must be nonzero");
  end

  localparam int unsigned CW = $clog2(INIT_CYC + RELEASE_CYC + 1);
  localparam int unsigned AW = ricp_pkg::CFG_AW;

  function automatic logic addr_bad(input logic [6:0] a, input logic fault);
    addr_bad = fault || a == ricp_pkg::ADDR_FALLBACK || a == ricp_pkg::ADDR_RSVD_MFG ||
               a == ricp_pkg::ADDR_RSVD_TEST || a == ricp_pkg::ADDR_GENCALL;
  endfunction : addr_bad

  function automatic logic cmd_is(input logic v, input logic [7:0] code, input logic [7:0] want);
    cmd_is = v && code == want;
  endfunction : cmd_is

  // three-stage synchronisers for pins
  logic [2:0] sup_sync;
  logic [2:0] ext_sync;
  logic       sup_ok;
  logic       ext_hi;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sup_sync <= 3'h0;
      ext_sync <= 3'h0;
      sup_ok   <= 1'b0;
      ext_hi   <= 1'b0;
    end else begin
      sup_sync <= {sup_sync[1:0], i_supply_above_threshold};
      ext_sync <= {ext_sync[1:0], i_external_reset_low_pin_n};
      if (sup_sync[1] == sup_sync[2]) sup_ok <= sup_sync[2];
      if (ext_sync[1] == ext_sync[2]) ext_hi <= ext_sync[2];
    end
  end

  logic hold_reset;
  assign hold_reset = !sup_ok || !ext_hi;

  ricp_pkg::ricp_state_t state;
  logic [CW-1:0]         cnt;
  logic                  wait_done;
  assign wait_done = state == ricp_pkg::RICP_WAIT && cnt >= CW'(RELEASE_CYC / 2);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ricp_pkg::RICP_RESET;
      cnt   <= '0;
    end else if (hold_reset) begin
      state <= ricp_pkg::RICP_RESET;
      cnt   <= '0;
    end else begin
      unique case (state)
        ricp_pkg::RICP_RESET: begin
          state <= ricp_pkg::RICP_WAIT;
          cnt   <= '0;
        end
        ricp_pkg::RICP_WAIT: begin
          // release settles in a fixed fraction of the 1 ms allowance
          if (wait_done) begin
            state <= ricp_pkg::RICP_INIT;
            cnt   <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ricp_pkg::RICP_INIT: begin
          if (cnt == CW'(INIT_CYC - 1)) begin
            state <= ricp_pkg::RICP_RUN;
            cnt   <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ricp_pkg::RICP_RUN: state <= ricp_pkg::RICP_RUN;
      endcase
    end
  end

  logic running;
  logic init_done;
  assign running   = state == ricp_pkg::RICP_RUN;
  assign init_done = state == ricp_pkg::RICP_INIT && cnt == CW'(INIT_CYC - 1);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_in_reset    <= 1'b1;
      o_init_active <= 1'b0;
      o_run         <= 1'b0;
    end else begin
      // levels follow the next state, so exactly one of the three stands
      o_in_reset    <= hold_reset || state == ricp_pkg::RICP_RESET ||
                       (state == ricp_pkg::RICP_WAIT && !wait_done);
      o_init_active <= !hold_reset && (wait_done ||
                       (state == ricp_pkg::RICP_INIT && !init_done));
      o_run         <= !hold_reset && (running || init_done);
    end
  end

  // working configuration memory
  logic [ricp_pkg::CFG_DW-1:0] cfg_ram [ricp_pkg::CFG_WORDS];
  logic                        cmd_ok;
  assign cmd_ok = running && !hold_reset;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < ricp_pkg::CFG_WORDS; i++) cfg_ram[i] <= ricp_pkg::CFG_RESET_VALUE;
    end else if (cmd_ok && i_param_wr && !o_flash_store) begin
      cfg_ram[i_param_addr] <= i_param_data;
    end
  end

  // store walks the whole RAM out to flash, one word each cycle the flash is not busy
  logic [ricp_pkg::CFG_AW-1:0] st_idx;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_flash_store <= 1'b0;
      o_flash_we    <= 1'b0;
      o_flash_addr  <= '0;
      o_flash_data  <= '0;
      st_idx        <= '0;
    end else if (!o_flash_store) begin
      o_flash_we <= 1'b0;
      if (cmd_ok && cmd_is(i_cmd_valid, i_cmd_code, ricp_pkg::CMD_STORE_ALL)) begin
        o_flash_store <= 1'b1;
        st_idx        <= '0;
      end
    end else if (hold_reset) begin
      o_flash_store <= 1'b0;
      o_flash_we    <= 1'b0;
    end else if (!i_flash_busy) begin
      o_flash_we   <= 1'b1;
      o_flash_addr <= st_idx;
      o_flash_data <= cfg_ram[st_idx];
      st_idx       <= st_idx + 1'b1;
      if (st_idx == AW'(ricp_pkg::CFG_WORDS - 1)) o_flash_store <= 1'b0;
    end else begin
      o_flash_we <= 1'b0;
    end
  end

  // jtag enable: boot command any time in run, power-up checks latched at the end of every init
  logic jtag_en;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      jtag_en    <= 1'b0;
      o_bus_addr <= ricp_pkg::ADDR_FALLBACK;
    end else if (hold_reset) begin
      jtag_en <= 1'b0;
    end else begin
      if (init_done) begin
        o_bus_addr <= i_addr_pin_fault ? ricp_pkg::ADDR_FALLBACK : i_bus_addr;
        if (i_flash_blank) jtag_en <= 1'b1;
        if (addr_bad(i_bus_addr, i_addr_pin_fault)) jtag_en <= 1'b1;
      end
      if (cmd_ok && cmd_is(i_cmd_valid, i_cmd_code, ricp_pkg::CMD_ENTER_BOOT))
        jtag_en <= 1'b1;
    end
  end

  // pin drive: low pwm and hi-z gpio outside run, factory default keeps gpio hi-z
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fast_pwm_pins         <= '0;
      o_general_output_pin    <= '0;
      o_general_output_pin_oe <= '0;
      o_seq_enable            <= 1'b0;
      o_jtag_enable           <= 1'b0;
      o_jtag_shared_gpio_oe   <= '0;
    end else begin
      o_jtag_enable <= jtag_en;
      if (!running || hold_reset) begin
        o_fast_pwm_pins         <= '0;
        o_general_output_pin    <= '0;
        o_general_output_pin_oe <= '0;
        o_seq_enable            <= 1'b0;
        o_jtag_shared_gpio_oe   <= '0;
      end else begin
        o_fast_pwm_pins         <= cfg_ram[0][ricp_pkg::FAST_PWM_N-1:0];
        o_general_output_pin    <= cfg_ram[1][ricp_pkg::GPIO_N-1:0];
        o_general_output_pin_oe <= cfg_ram[2][ricp_pkg::GPIO_N-1:0];
        o_seq_enable            <= cfg_ram[3][0];
        o_jtag_shared_gpio_oe   <= jtag_en ? '0 : cfg_ram[4][ricp_pkg::JTAG_SHARED_N-1:0];
      end
    end
  end

  a_init_pins_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_init_active |-> (o_fast_pwm_pins == '0 && o_general_output_pin_oe == '0))
    else $error("pins driven during init");
  a_reset_no_run: assert property (@(posedge i_clk) disable iff (!i_rstn)
    hold_reset |=> !o_run)
    else $error("run while reset held");
  a_store_start: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (cmd_ok && !o_flash_store && i_cmd_valid && i_cmd_code == ricp_pkg::CMD_STORE_ALL)
      |=> o_flash_store)
    else $error("store not started");
  a_cmd_ignored: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!running && !o_flash_store) |=> !o_flash_store)
    else $error("store accepted before run");
  a_jtag_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (jtag_en && !hold_reset) |=> jtag_en)
    else $error("jtag enable dropped");
  a_boot_cmd: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (cmd_ok && !hold_reset && i_cmd_valid && i_cmd_code == ricp_pkg::CMD_ENTER_BOOT)
      |=> ##1 o_jtag_enable)
    else $error("boot command ignored");
  a_ram_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (cmd_ok && i_param_wr && !o_flash_store) |=> cfg_ram[$past(i_param_addr)] == $past(i_param_data))
    else $error("param write lost");
  a_run_gpio_z: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !o_run |=> o_jtag_shared_gpio_oe == '0 || o_run)
    else $error("shared gpio driven outside run");
  a_init_done_run: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (init_done && !hold_reset) |=> o_run)
    else $error("run not entered after init");
  a_flash_walk: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (o_flash_store && !hold_reset && !i_flash_busy) |=> o_flash_we)
    else $error("store walk stalled");
  a_refused_wr: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ((!cmd_ok || o_flash_store) && i_param_wr)
      |=> cfg_ram[$past(i_param_addr)] == $past(cfg_ram[i_param_addr]))
    else $error("refused param write landed");
  a_reset_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
    hold_reset |=> o_in_reset)
    else $error("reset level missing");
  a_jtag_default: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!jtag_en && !init_done && !(cmd_ok && cmd_is(i_cmd_valid, i_cmd_code,
      ricp_pkg::CMD_ENTER_BOOT))) |=> !jtag_en)
    else $error("jtag enabled without cause");
  a_shared_gpio_off: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_jtag_enable |-> o_jtag_shared_gpio_oe == '0)
    else $error("shared gpio driven with jtag on");
  a_state_levels: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $onehot({o_in_reset, o_init_active, o_run}))
    else $error("state levels overlap");
  a_addr_fallback: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (init_done && !hold_reset && i_addr_pin_fault) |=> o_bus_addr == ricp_pkg::ADDR_FALLBACK)
    else $error("address fallback missing");
  a_blank_jtag: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (init_done && !hold_reset && i_flash_blank) |=> jtag_en)
    else $error("blank flash left jtag off");
  a_bad_addr_jtag: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (init_done && !hold_reset && addr_bad(i_bus_addr, i_addr_pin_fault)) |=> jtag_en)
    else $error("bad address left jtag off");
  a_reset_no_seq: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_in_reset |-> !o_seq_enable)
    else $error("sequencing during reset");
endmodule : ricp_core

/* tb/ricp_flash_model.sv */
`timescale 1ns/1ps
module ricp_flash_model (
  // clock and bench control
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  input  wire logic        i_clear,
  // flash port of the loader
  input  wire logic        i_flash_store,
  input  wire logic        i_flash_we,
  input  wire logic [3:0]  i_flash_addr,
  input  wire logic [15:0] i_flash_data,
  output logic             o_flash_busy,
  // bookkeeping
  output logic [4:0]       o_writes,
  output logic             o_order_bad
);
  logic [15:0] mem [16];
  initial begin
    o_flash_busy = 1'b0;
    o_writes = 5'h00;
    o_order_bad = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_clear) begin
      o_writes <= 5'h00;
      o_order_bad <= 1'b0;
    end else if (i_flash_we) begin
      mem[i_flash_addr] <= i_flash_data;
      o_writes <= o_writes + 5'h01;
      if (i_flash_addr !== o_writes[3:0]) o_order_bad <= 1'b1;
    end
    // a slow flash stalls every other cycle of a store
    o_flash_busy <= #1 i_slow & i_flash_store & ~o_flash_busy;
  end
endmodule : ricp_flash_model

/* tb/reset_init_config_port_control_test.sv */
`timescale 1ns/1ps
module reset_init_config_port_control_test;
  localparam int RC = 8;
  localparam int IC = 20;
  typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} ricp_row_t;
  typedef struct packed {logic [6:0] a; logic f; logic b; logic j;} ricp_pu_t;
  logic i_clk = 0, rstn = 0, sup = 0, ext_n = 1, fault = 0, blank = 0;
  logic cmd_v = 0, pwr = 0, slow = 0, clr = 0, bad;
  logic [6:0]  addr_i = 7'h65;
  logic [7:0]  cmd = 8'h00;
  logic [3:0]  paddr = 4'h0;
  logic [15:0] pdata = 16'h0000;
  logic in_rst, init, run, seq, fstore, fwe, busy, jtag, obad;
  logic [6:0] addr_o;
  logic [3:0] faddr, pwm, jgoe;
  logic [15:0] fdata;
  logic [7:0] gout, gout_oe;
  logic [4:0] nw;
  int n_errors = 0, checked = 0, i, k;
  ricp_row_t rows [5] = '{'{4'h0, 16'hA5A5, 16'h0005}, '{4'h1, 16'h12C3, 16'h00C3},
    '{4'h2, 16'hFF0F, 16'h000F}, '{4'h3, 16'h0001, 16'h0001}, '{4'h4, 16'h000A, 16'h000A}};
  ricp_pu_t pus [5] = '{'{7'h65, 1'b0, 1'b1, 1'b1}, '{7'h00, 1'b1, 1'b0, 1'b1},
    '{7'h0B, 1'b0, 1'b0, 1'b1}, '{7'h7F, 1'b0, 1'b0, 1'b1}, '{7'h00, 1'b0, 1'b0, 1'b1}};
  always #2.5 i_clk = ~i_clk;
  ricp_core #(.RELEASE_CYC(RC), .INIT_CYC(IC)) ricp_core_inst (
    .i_clk(i_clk), .i_rstn(rstn), .i_supply_above_threshold(sup),
    .i_external_reset_low_pin_n(ext_n), .i_bus_addr(addr_i), .i_addr_pin_fault(fault),
    .i_flash_blank(blank), .i_cmd_valid(cmd_v), .i_cmd_code(cmd), .i_param_wr(pwr),
    .i_param_addr(paddr), .i_param_data(pdata), .i_flash_busy(busy), .o_in_reset(in_rst),
    .o_init_active(init), .o_run(run), .o_seq_enable(seq), .o_bus_addr(addr_o),
    .o_flash_store(fstore), .o_flash_addr(faddr), .o_flash_data(fdata), .o_flash_we(fwe),
    .o_fast_pwm_pins(pwm), .o_general_output_pin(gout), .o_general_output_pin_oe(gout_oe),
    .o_jtag_enable(jtag), .o_jtag_shared_gpio_oe(jgoe));
  ricp_flash_model ricp_flash_model_inst (.i_clk(i_clk), .i_slow(slow), .i_clear(clr),
    .i_flash_store(fstore), .i_flash_we(fwe), .i_flash_addr(faddr), .i_flash_data(fdata),
    .o_flash_busy(busy), .o_writes(nw), .o_order_bad(obad));
  function automatic logic [15:0] obs(input logic [3:0] a);
    case (a)
      4'h0: obs = {12'h000, pwm};
      4'h1: obs = {8'h00, gout};
      4'h2: obs = {8'h00, gout_oe};
      4'h3: obs = {15'h0000, seq};
      default: obs = {12'h000, jgoe};
    endcase
  endfunction : obs
  task check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task send(input logic v, input logic [7:0] c, input logic [3:0] a, input logic [15:0] d);
    cmd_v = v;
    pwr = ~v;
    cmd = c;
    paddr = a;
    pdata = d;
    tick(1);
    cmd_v = 0;
    pwr = 0;
    tick(1);
  endtask : send
  task boot(input logic [6:0] ad, input logic f, input logic b);
    rstn = 0;
    addr_i = ad;
    fault = f;
    blank = b;
    tick(12);
    rstn = 1;
    send(1, ricp_pkg::CMD_ENTER_BOOT, 4'h0, 16'h0000);
    send(0, 8'h00, 4'h3, 16'h0001);
    for (k = 0; k < 200 && run !== 1'b1; k++) tick(1);
    check(run, 1);
  endtask : boot
  task results;
    $display("counts checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  initial begin
    #100000;
    n_errors++;
    results();
  end
  initial begin
    tick(12);
    check({in_rst, jtag, run, addr_o}, {3'b100, 7'h7E});
    check({pwm, gout_oe, jgoe}, 16'h0000);
    rstn = 1;
    tick(40);
    check(in_rst, 1);
    sup = 1;
    boot(7'h65, 0, 0);
    check({jtag, seq, pwm, gout_oe, addr_o}, {14'h0000, 7'h65});
    $display("test reset done");
    for (i = 0; i < 5; i++) begin
      send(0, 8'h00, rows[i].a, rows[i].d);
      tick(2);
      check(obs(rows[i].a), rows[i].e);
    end
    check(nw, 0);
    $display("test table done");
    slow = 1;
    send(1, ricp_pkg::CMD_STORE_ALL, 4'h0, 16'h0000);
    send(0, 8'h00, 4'h0, 16'h0000);
    for (k = 0; k < 100 && fstore === 1'b1; k++) tick(1);
    tick(4);
    check({nw, obad, pwm}, {5'h10, 1'b0, 4'h5});
    for (i = 0; i < 5; i++) check(ricp_flash_model_inst.mem[i], rows[i].d);
    check(ricp_flash_model_inst.mem[15], ricp_pkg::CFG_RESET_VALUE);
    clr = 1;
    tick(1);
    clr = 0;
    slow = 0;
    send(1, ricp_pkg::CMD_STORE_ALL, 4'h0, 16'h0000);
    for (k = 0; k < 100 && fstore === 1'b1; k++) tick(1);
    tick(4);
    check({nw, obad}, {5'h10, 1'b0});
    $display("test store done");
    send(1, ricp_pkg::CMD_ENTER_BOOT, 4'h0, 16'h0000);
    tick(1);
    check({jtag, jgoe}, 5'h10);
    ext_n = 0;
    tick(8);
    check(in_rst, 1);
    tick(30);
    check({in_rst, jtag}, 2'b10);
    ext_n = 1;
    for (k = 0; k < 100 && init !== 1'b1; k++) tick(1);
    check(k <= RC + 4, 1);
    bad = 0;
    for (k = 0; k < 1000 && init === 1'b1; k++) begin
      bad = bad | (|{pwm, gout_oe, jgoe, run});
      tick(1);
    end
    check({k[15:0]}, IC);
    check(bad, 0);
    tick(2);
    check({run, jtag}, 2'b10);
    $display("test external reset done");
    for (i = 0; i < 5; i++) begin
      boot(pus[i].a, pus[i].f, pus[i].b);
      addr_i = 7'h65;
      fault = 0;
      blank = 0;
      tick(4);
      check(jtag, pus[i].j);
      if (pus[i].f) check(addr_o, 7'h7E);
    end
    $display("test power-up decisions done");
    results();
  end
endmodule : reset_init_config_port_control_test
